// ---- design/scs_clock_switch.sv ----
// clock source switch, power sequence start status and domain clock gating
`timescale 1ns/1ps
module scs_clock_switch
  import scs_pkg::*;
#(
  parameter int NSRC     = 4,
  parameter int LOSS_LIM = LOSS_CYC,
  parameter int WAITS    = XTRA_WAIT
) (
  // clock and reset
  input  wire logic             CLK_SYS,
  input  wire logic             RST_B,
  // register port
  input  wire logic [3:0]       ADDR,
  input  wire logic [15:0]      WDATA,
  input  wire logic             WR,
  input  wire logic             RD,
  output logic      [15:0]      RDATA,
  // clock sources: presence and target ticks from the oscillators
  input  wire logic [NSRC-1:0]  SRC_PRESENT,
  input  wire logic [NSRC-1:0]  SRC_TICK,
  // power sequence inputs
  input  wire logic             SUPPLY_OK,
  input  wire logic             EXT_TRIG,
  // clock mux and gate controls
  output logic [SRC_W-1:0]      MUX_SEL,
  output logic                  MUX_DETACH,
  output logic                  GATE_EN_MAIN,
  output logic                  GATE_EN_FIRST
);

  typedef struct packed {
    logic [2:0][NSRC-1:0] pres_sy;
    logic [2:0][NSRC-1:0] tick_sy;
    logic [2:0]           sup_sy;
    logic [2:0]           trg_sy;
    logic [NSRC-1:0]      pres;
    logic                 sup_ok;
    logic                 trg_lvl;
    logic                 trg_prev;
    scs_sw_t              sw;
    logic [SRC_W-1:0]     cur;
    logic [SRC_W-1:0]     tgt;
    logic                 detach;
    logic                 emerg;
    logic [8:0]           loss_cnt;
    scs_psm_t             psm;
    logic [3:0]           wait_cnt;
    logic                 run_b;
    logic                 en_a;
    logic                 en_b;
    logic [1:0]           tsel;
    logic                 last_b;
    logic                 on_m;
    logic                 on_1;
    logic                 off_m;
    logic                 off_1;
    logic [1:0]           step_tsel;
    logic                 gate_m;
    logic                 gate_1;
    logic [15:0]          rdata;
  } scs_state_t;

  scs_state_t s_q;
  scs_state_t s_d;
  scs_bus_t   bus;

  assign bus = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

  logic [NSRC-1:0] tick_edge;
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      // stage 0 feeds only stage 1; edges are judged between stages 1 and 2
      assign tick_edge[gi] = s_q.tick_sy[1][gi] & ~s_q.tick_sy[2][gi];
    end
  endgenerate

  always_comb begin
    s_d = s_q;
    s_d.pres_sy  = {s_q.pres_sy[1:0], SRC_PRESENT};
    s_d.tick_sy  = {s_q.tick_sy[1:0], SRC_TICK};
    s_d.sup_sy   = {s_q.sup_sy[1:0], SUPPLY_OK};
    s_d.trg_sy   = {s_q.trg_sy[1:0], EXT_TRIG};
    for (int i = 0; i < NSRC; i++) begin
      if (s_q.pres_sy[1][i] == s_q.pres_sy[2][i]) begin
        s_d.pres[i] = s_q.pres_sy[2][i];
      end
    end
    if (s_q.sup_sy[1] == s_q.sup_sy[2]) begin
      s_d.sup_ok = s_q.sup_sy[2];
    end
    if (s_q.trg_sy[1] == s_q.trg_sy[2]) begin
      s_d.trg_lvl = s_q.trg_sy[2];
    end
    s_d.trg_prev = s_q.trg_lvl;

    // clock switch sequencing
    unique case (s_q.sw)
      SW_IDLE: begin
        // software checks presence of both clocks first; hardware does not refuse
        if (bus.wr && bus.addr == ADDR_CLK_SEL) begin
          s_d.tgt    = bus.wdata[SEL_SRC_LSB +: SRC_W];
          s_d.detach = 1'b1;
          s_d.sw     = SW_DETACH;
        end
      end
      SW_DETACH: begin
        s_d.sw = SW_SYNC;
      end
      SW_SYNC: begin
        // wait for an edge of the new target; with no target the system stays detached
        if (tick_edge[s_q.tgt]) begin
          s_d.cur    = s_q.tgt;
          s_d.detach = 1'b0;
          s_d.sw     = SW_IDLE;
        end
      end
      default: s_d.sw = SW_IDLE;
    endcase

    // clock-loss watchdog on the running source
    if (tick_edge[s_q.cur] || s_q.sw != SW_IDLE || s_q.detach) begin
      s_d.loss_cnt = '0;
    end else if (s_q.loss_cnt != 9'(LOSS_LIM)) begin
      s_d.loss_cnt = s_q.loss_cnt + 9'h001;
    end
    if (s_q.sw == SW_IDLE && (s_q.loss_cnt == 9'(LOSS_LIM) || !s_q.pres[s_q.cur])
        && s_q.cur != BACKUP_SRC) begin
      // no frequency ratio limit applies here
      s_d.cur      = BACKUP_SRC;
      s_d.detach   = 1'b0;
      s_d.emerg    = 1'b1;
      s_d.loss_cnt = '0;
    end

    // power sequence control
    if (bus.wr && bus.addr == ADDR_SEQ_CTRL) begin
      s_d.en_a      = bus.wdata[SQ_AEN_BIT] | s_q.en_a;
      s_d.en_b      = bus.wdata[SQ_BEN_BIT] | s_q.en_b;
      s_d.tsel      = bus.wdata[SQ_TSEL_LSB +: 2];
      s_d.on_m      = bus.wdata[SQ_ON_M_BIT];
      s_d.on_1      = bus.wdata[SQ_ON_1_BIT];
      s_d.off_m     = bus.wdata[SQ_OFF_M_BIT];
      s_d.off_1     = bus.wdata[SQ_OFF_1_BIT];
      s_d.step_tsel = bus.wdata[SQ_STEP_LSB +: 2];
    end
    if (bus.wr && bus.addr == ADDR_CLK_STAT && bus.wdata[ST_EMERG_BIT]) begin
      s_d.emerg = 1'b0;
    end

    unique case (s_q.psm)
      PSM_IDLE: begin
        // a non-software trigger must be seen as a rising edge
        if ((s_q.en_a || s_q.en_b) &&
            (s_q.tsel == TRG_SW || (s_q.trg_lvl && !s_q.trg_prev))) begin
          // first then second sequence in turn
          s_d.run_b    = s_q.last_b ? 1'b0 : s_q.en_b & ~s_q.en_a;
          s_d.wait_cnt = 4'(WAITS);
          s_d.psm      = PSM_WAIT;
        end
      end
      PSM_WAIT: begin
        if (s_q.wait_cnt == 4'h0) begin
          s_d.psm = PSM_SUPPLY;
        end else begin
          s_d.wait_cnt = s_q.wait_cnt - 4'h1;
        end
      end
      PSM_SUPPLY: begin
        if (s_q.sup_ok) begin
          s_d.psm = PSM_RUN;
        end
      end
      PSM_RUN: begin
        // start is visible: enable cleared, status back to zero
        if (s_q.run_b) begin
          s_d.en_b = 1'b0;
        end else begin
          s_d.en_a = 1'b0;
        end
        s_d.last_b = s_q.run_b;
        s_d.psm    = PSM_IDLE;
      end
      default: s_d.psm = PSM_IDLE;
    endcase

    // stepper gating; clock-off only counts with a nonzero trigger select
    s_d.gate_m = s_q.on_m & ~(s_q.off_m & (s_q.step_tsel != STEP_TSEL_RST));
    s_d.gate_1 = s_q.on_1 & ~(s_q.off_1 & (s_q.step_tsel != STEP_TSEL_RST));

    s_d.rdata = '0;
    if (bus.rd) begin
      unique case (bus.addr)
        ADDR_CLK_SEL: s_d.rdata[SEL_SRC_LSB +: SRC_W] = s_q.tgt;
        ADDR_CLK_STAT: begin
          s_d.rdata[ST_BUSY_BIT]           = (s_q.sw != SW_IDLE);
          s_d.rdata[ST_EMERG_BIT]          = s_q.emerg;
          s_d.rdata[ST_CUR_LSB +: SRC_W]   = s_q.cur;
          s_d.rdata[ST_DET_BIT]            = s_q.detach;
        end
        ADDR_SEQ_CTRL: begin
          s_d.rdata[SQ_AEN_BIT]            = s_q.en_a;
          s_d.rdata[SQ_BEN_BIT]            = s_q.en_b;
          s_d.rdata[SQ_TSEL_LSB +: 2]      = s_q.tsel;
          s_d.rdata[SQ_ON_M_BIT]           = s_q.on_m;
          s_d.rdata[SQ_ON_1_BIT]           = s_q.on_1;
          s_d.rdata[SQ_OFF_M_BIT]          = s_q.off_m;
          s_d.rdata[SQ_OFF_1_BIT]          = s_q.off_1;
          s_d.rdata[SQ_STEP_LSB +: 2]      = s_q.step_tsel;
        end
        ADDR_SEQ_STAT: begin
          s_d.rdata[SS_PSM_LSB +: 3]       = s_q.psm;
          s_d.rdata[SS_LAST_BIT]           = s_q.last_b;
        end
        default: s_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA         = s_q.rdata;
  assign MUX_SEL       = s_q.cur;
  assign MUX_DETACH    = s_q.detach;
  assign GATE_EN_MAIN  = s_q.gate_m;
  assign GATE_EN_FIRST = s_q.gate_1;

endmodule : scs_clock_switch

// ---- design/scs_pkg.sv ----
// package: register map, field layout, states and timing for the clock switch block
// Notes on behaviour
// - once the second sequence has started, the state machine status reads zero.
// - the sequencer holds at its supply wait step until the supply level is good.
// - extra wait cycles may be inserted between trigger and visible start.
// - each sequence enable bit is cleared by hardware once that sequence starts.
// - with a non-software trigger, the enable stays set until that trigger fires.
// - last-sequence flag reads one after the second sequence ran.
// - a triggered switch detaches the current clock, even without a target clock.
// - each switch request is synchronised to the target clock before it completes.
// - a lost current clock forces an emergency switch to the backup clock.
// - the stepper register holds one clock enable for each of two domains.
// - clock-off bits act only while the stepper trigger select is nonzero.
package scs_pkg;

  localparam logic [3:0] ADDR_CLK_SEL   = 4'h0;
  localparam logic [3:0] ADDR_CLK_STAT  = 4'h4;
  localparam logic [3:0] ADDR_SEQ_CTRL  = 4'h8;
  localparam logic [3:0] ADDR_SEQ_STAT  = 4'hc;

  localparam int SRC_W        = 2;
  localparam int SEL_SRC_LSB  = 0;
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_EMERG_BIT = 1;
  localparam int ST_CUR_LSB   = 4;
  localparam int ST_DET_BIT   = 8;
  localparam int SQ_AEN_BIT   = 0;
  localparam int SQ_BEN_BIT   = 1;
  localparam int SQ_TSEL_LSB  = 4;
  localparam int SQ_ON_M_BIT  = 8;
  localparam int SQ_ON_1_BIT  = 9;
  localparam int SQ_OFF_M_BIT = 10;
  localparam int SQ_OFF_1_BIT = 11;
  localparam int SQ_STEP_LSB  = 12;
  localparam int SS_PSM_LSB   = 0;
  localparam int SS_LAST_BIT  = 4;

  localparam logic [1:0] RST_SRC    = 2'h0;
  localparam logic [1:0] BACKUP_SRC = 2'h0;
  localparam logic [1:0] TRG_SW     = 2'h0;
  localparam logic [1:0] STEP_TSEL_RST = 2'h0;

  // target clock presence sampled per edge, three stages then agreement
  localparam int SYNC_STAGES  = 3;
  localparam int LOSS_NS      = 400;
  localparam int CLK_NS       = 20;
  localparam int LOSS_CYC     = LOSS_NS / CLK_NS;
  localparam int XTRA_WAIT    = 4;

  typedef enum logic [2:0] {
    PSM_IDLE   = 3'b000,
    PSM_WAIT   = 3'b001,
    PSM_SUPPLY = 3'b010,
    PSM_RUN    = 3'b011
  } scs_psm_t;

  typedef enum logic [1:0] {
    SW_IDLE   = 2'b00,
    SW_DETACH = 2'b01,
    SW_SYNC   = 2'b10
  } scs_sw_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } scs_bus_t;

endpackage : scs_pkg

// ---- testbench/scs_clock_switch_monitor.sv ----
// checker: port-level assertions for the clock switch block
`timescale 1ns/1ps
module scs_clock_switch_monitor
  import scs_pkg::*;
#(parameter int NSRC = 4) (
  // clock and reset
  input wire logic            CLK_SYS,
  input wire logic            RST_B,
  // register port
  input wire logic [3:0]      ADDR,
  input wire logic [15:0]     WDATA,
  input wire logic            WR,
  input wire logic            RD,
  input wire logic [15:0]     RDATA,
  // sources and controls
  input wire logic [NSRC-1:0] SRC_PRESENT,
  input wire logic [SRC_W-1:0] MUX_SEL,
  input wire logic            MUX_DETACH,
  input wire logic            GATE_EN_MAIN,
  input wire logic            GATE_EN_FIRST
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);
  logic [1:0] tgt_q;
  wire wr8 = WR && ADDR == ADDR_SEQ_CTRL;
  wire sw  = WR && ADDR == ADDR_CLK_SEL && !MUX_DETACH && WDATA[1:0] != MUX_SEL;
  wire gm  = WDATA[SQ_ON_M_BIT] && !(WDATA[SQ_OFF_M_BIT] && WDATA[13:12] != 2'h0);
  wire g1  = WDATA[SQ_ON_1_BIT] && !(WDATA[SQ_OFF_1_BIT] && WDATA[13:12] != 2'h0);
  // remembered target lets the end of a switch be tied to its request
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) tgt_q <= 2'h0;
    else if (sw) tgt_q <= WDATA[1:0];
  end
  sequence s_req; sw; endsequence
  // a tick seen in the first sync cycle may end the switch three cycles after the request
  sequence s_done; MUX_DETACH [*2] ##[1:40] !MUX_DETACH; endsequence
  AST_SW_DONE: assert property (s_req |=> s_done)
    else $error("switch did not detach and finish");
  AST_SEL_TGT: assert property ($fell(MUX_DETACH) && &SRC_PRESENT |-> MUX_SEL == tgt_q)
    else $error("switch ended on wrong source");
  AST_SEL_HOLD: assert property (!MUX_DETACH && !$past(MUX_DETACH) && &SRC_PRESENT
    |-> $stable(MUX_SEL)) else $error("source changed while attached");
  AST_EMERG: assert property (!SRC_PRESENT[MUX_SEL] |-> ##[1:40] MUX_SEL == BACKUP_SRC)
    else $error("no emergency switch to backup");
  AST_RD_IDLE: assert property (!$past(RD) |-> RDATA == 16'h0)
    else $error("read data outside read slot");
  // the field lands one edge after the write and the gate one edge later
  AST_GATE_M: assert property ($past(wr8, 2) |-> GATE_EN_MAIN == $past(gm, 2))
    else $error("main gate enable wrong");
  AST_GATE_F: assert property ($past(wr8, 2) |-> GATE_EN_FIRST == $past(g1, 2))
    else $error("first gate enable wrong");
  AST_GATE_HOLD: assert property (!$past(wr8, 2) |-> $stable({GATE_EN_MAIN, GATE_EN_FIRST}))
    else $error("gate enable moved without write");
endmodule : scs_clock_switch_monitor

bind scs_clock_switch scs_clock_switch_monitor #(.NSRC(NSRC)) u_scs_clock_switch_monitor (
  .CLK_SYS(CLK_SYS), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .RDATA(RDATA), .SRC_PRESENT(SRC_PRESENT), .MUX_SEL(MUX_SEL), .MUX_DETACH(MUX_DETACH),
  .GATE_EN_MAIN(GATE_EN_MAIN), .GATE_EN_FIRST(GATE_EN_FIRST));

// ---- testbench/scs_clock_switch_tb.sv ----
// testbench: register-driven checks of switching, sequencing and gating
`timescale 1ns/1ps
module scs_clock_switch_tb;
  import scs_pkg::*;
  logic        clk, rst_b, wr, rd, rd_p, sup, ext, det, gm, g1;
  logic [3:0]  addr, pres, tick;
  logic [15:0] wdata, rdata, d;
  logic [1:0]  sel;
  logic [2:0]  tc = 3'h0;
  logic [1:0]  tg[3] = '{2'h1, 2'h3, 2'h2};
  logic [31:0] lf;
  logic [15:0] exp_q[$];
  int          bad_count, check_count, n;

  scs_clock_switch u_scs_clock_switch (.CLK_SYS(clk), .RST_B(rst_b), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .SRC_PRESENT(pres), .SRC_TICK(tick),
    .SUPPLY_OK(sup), .EXT_TRIG(ext), .MUX_SEL(sel), .MUX_DETACH(det),
    .GATE_EN_MAIN(gm), .GATE_EN_FIRST(g1));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk; // one fixed frequency, no stepping to respect
  end
  // every source ticks every 8 cycles, well inside the loss limit
  always @(posedge clk) begin
    tc <= tc + 3'h1;
    tick <= {4{tc[2]}};
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
    addr <= a; wdata <= v; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(posedge clk);
  endtask : rd_reg
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out

  // read data stand only in the cycle after the strobe
  always @(posedge clk) rd_p <= rd;
  always @(negedge clk) if (rd_p) chk(rdata, exp_q.pop_front());

  initial begin
    #200000;
    bad_count++;
    close_out();
  end

  initial begin
    rst_b = 0; addr = 0; wdata = 0; wr = 0; rd = 0; rd_p = 0;
    pres = 4'hf; tick = 0; sup = 1; ext = 0; lf = 32'h594c57bf;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    repeat (12) begin
      lf = lfsr(lf);
      d = lf[15:0] & 16'h3f00;
      wr_reg(ADDR_SEQ_CTRL, d);
      // gates settle at the edge where the task returns, so look mid-cycle
      @(negedge clk);
      chk(gm, d[8] && !(d[10] && d[13:12] != 2'h0));
      chk(g1, d[9] && !(d[11] && d[13:12] != 2'h0));
      @(posedge clk);
    end
    $display("gate test done");
    foreach (tg[i]) begin
      wr_reg(ADDR_CLK_SEL, {14'h0, tg[i]}); // all sources present and ticking
      chk(det, 1'b1);
      n = 0;
      while (det && n < 100) begin // next switch only after this one ends
        @(posedge clk);
        n++;
      end
      chk(sel, tg[i]);
      rd_reg(ADDR_CLK_STAT, {10'h0, tg[i], 4'h0});
    end
    rd_reg(4'h2, 16'h0);
    $display("switch test done");
    wr_reg(ADDR_SEQ_CTRL, 16'h0011);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_SEQ_CTRL, 16'h0011);
    ext <= 1'b1;
    repeat (10) @(posedge clk);
    ext <= 1'b0;
    repeat (20) @(posedge clk);
    rd_reg(ADDR_SEQ_CTRL, 16'h0010);
    rd_reg(ADDR_SEQ_STAT, 16'h0000);
    sup <= 1'b0;
    wr_reg(ADDR_SEQ_CTRL, 16'h0002);
    rd_reg(ADDR_SEQ_STAT, 16'h0001);
    repeat (20) @(posedge clk);
    rd_reg(ADDR_SEQ_STAT, 16'h0002);
    sup <= 1'b1;
    repeat (15) @(posedge clk);
    rd_reg(ADDR_SEQ_STAT, 16'h0010);
    rd_reg(ADDR_SEQ_CTRL, 16'h0000);
    $display("sequence test done");
    pres <= 4'hb; // a running source vanishes; no source is toggled by software
    repeat (40) @(posedge clk);
    chk(sel, BACKUP_SRC);
    rd_reg(ADDR_CLK_STAT, 16'h0002);
    wr_reg(ADDR_CLK_STAT, 16'h0002);
    rd_reg(ADDR_CLK_STAT, 16'h0000);
    $display("emergency test done");
    close_out();
  end
endmodule : scs_clock_switch_tb
